// *** logic/pxb_pkg.sv ***
`default_nettype none
package pxb_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NPIN = 24;
  localparam int NFN  = 14;
  typedef logic [4:0] pxb_pin_idx_type;
  typedef logic [3:0] pxb_fn_idx_type;
  typedef logic [1:0] pxb_clk_div_type;

  // ****************************************
  // Register addresses and reset values
  // ****************************************
  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_PORT0_DRIVE = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_DRIVE = 8'hA5;
  localparam logic [7:0] ADDR_PORT2_DRIVE = 8'hA6;
  localparam logic [7:0] ADDR_PORT1_ADSEL = 8'hAD;
  localparam logic [7:0] ADDR_ROUTE_B     = 8'hE2;
  localparam logic [7:0] ADDR_ROUTE_C     = 8'hE3;
  localparam logic [7:0] RST_LATCH        = 8'hFF;
  localparam logic [7:0] RST_DRIVE        = 8'h00;
  localparam logic [7:0] RST_ADSEL        = 8'hFF;
  localparam logic [7:0] RST_ROUTE        = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RB_CLKOUT = 7;
  localparam int RB_T2EX   = 6;
  localparam int RB_T2     = 5;
  localparam int RB_INT1   = 4;
  localparam int RB_T1     = 3;
  localparam int RB_INT0   = 2;
  localparam int RB_T0     = 1;
  localparam int RB_CP1    = 0;
  localparam int RC_PUOFF  = 7;
  localparam int RC_XBAR   = 6;
  localparam int RC_CONV_B = 5;
  localparam int RC_T4EX   = 4;
  localparam int RC_T4     = 3;
  localparam int RC_UART   = 2;
  localparam int RC_MEMIF  = 1;
  localparam int RC_CONV_A = 0;

  // ****************************************
  // Crossbar functions in priority order
  // ****************************************
  localparam int FN_TX1 = 0;
  localparam int FN_RX1 = 1;
  localparam int FN_CP1 = 2;
  localparam int FN_T0 = 3;
  localparam int FN_INT0 = 4;
  localparam int FN_T1 = 5;
  localparam int FN_INT1 = 6;
  localparam int FN_T2 = 7;
  localparam int FN_T2EX = 8;
  localparam int FN_T4 = 9;
  localparam int FN_T4EX = 10;
  localparam int FN_CLKOUT = 11;
  localparam int FN_CONV_A = 12;
  localparam int FN_CONV_B = 13;

  // ****************************************
  // Pin map
  // ****************************************
  localparam int PIN_WR_N  = 7;
  localparam int PIN_RD_N  = 6;
  localparam int PIN_ALE   = 5;
  localparam int PORT1_LSB = 8;
  localparam int PORT2_LSB = 16;
  localparam int PORT_W    = 8;
endpackage
`default_nettype wire

// *** logic/pxb_pin_sync.sv ***
`default_nettype none
module pxb_pin_sync #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pxb_sync_type;

  pxb_sync_type state;
  pxb_sync_type next_state;

  // First stage feeds only the second stage
  always_comb begin
    next_state.s1 = d;
    next_state.s2 = state.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q = state.s2;
endmodule
`default_nettype wire

// *** logic/pxb_clock_out_div.sv ***
`default_nettype none
module pxb_clock_out_div
  import pxb_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire pxb_pkg::pxb_clk_div_type div,
  output logic                          clk_out
);
  import pxb_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
  } pxb_div_type;

  pxb_div_type state;
  pxb_div_type next_state;

  always_comb begin
    next_state.cnt = state.cnt + 3'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Divide by one has no flop source: it is the inverted clock itself
  always_comb begin
    case (div)
      2'h0: clk_out = ~clk;
      2'h1: clk_out = ~state.cnt[0];
      2'h2: clk_out = ~state.cnt[1];
      default: clk_out = ~state.cnt[2];
    endcase
  end
endmodule
`default_nettype wire

// *** logic/pxb_port_crossbar.sv ***
`default_nettype none
module pxb_port_crossbar
  import pxb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [7:0]            sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire logic [7:0]            sfr_wdata,
  input  wire logic                  sfr_rd,
  output logic      [7:0]            sfr_rdata,
  input  wire logic [NPIN-1:0]       pin_in,
  output logic      [NPIN-1:0]       pin_out,
  output logic      [NPIN-1:0]       pin_oe,
  output logic      [NPIN-1:0]       pullup_en,
  input  wire logic [NPIN-1:0]       reserved_pins,
  input  wire logic [NPIN-1:0]       reserved_out,
  input  wire logic [NPIN-1:0]       reserved_od,
  input  wire logic                  second_uart_tx,
  input  wire logic                  second_uart_mode0,
  input  wire logic                  comparator1_out,
  input  wire pxb_pkg::pxb_clk_div_type clock_out_divider,
  input  wire logic                  memif_active,
  input  wire logic                  memif_nonmux,
  input  wire logic                  memif_wr_n,
  input  wire logic                  memif_rd_n,
  input  wire logic                  memif_ale,
  input  wire logic [15:0]           memif_addr,
  output logic      [NFN-1:0]        periph_in
);
  import pxb_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  typedef struct packed {
    logic [7:0] port0_data_latch;
    logic [7:0] port1_data_latch;
    logic [7:0] port2_data_latch;
    logic [7:0] port0_drive_select;
    logic [7:0] port1_drive_select;
    logic [7:0] port2_drive_select;
    logic [7:0] port1_analog_digital_select;
    logic [7:0] crossbar_route_b;
    logic [7:0] crossbar_route_c;
    logic [7:0] rdata;
  } pxb_regs_type;

  pxb_regs_type state;
  pxb_regs_type next_state;

  logic [NPIN-1:0] pin_s;
  logic [NPIN-1:0] pin_rd;
  logic [NPIN-1:0] latch;
  logic [NPIN-1:0] push_pull;
  logic [NPIN-1:0] analog;
  logic [NPIN-1:0] skip;
  logic [NPIN-1:0] memif_drv;
  logic [NPIN-1:0] memif_val;
  logic [NPIN-1:0] pin_owned;
  logic [NFN-1:0]  fn_en;
  logic [NFN-1:0]  fn_valid;
  logic [NFN-1:0]  fn_out;
  logic [NFN-1:0]  fn_is_out;
  logic            crossbar_on;
  logic            pullup_global_off;
  logic            memif_low_port_en;
  logic            clock_out;
  logic            found;
  int              ptr;
  pxb_pin_idx_type pin_of [NFN];
  pxb_fn_idx_type  pin_fn [NPIN];

  // Open-drain and push-pull share this decode for every pin
  function automatic logic [1:0] drive_pin(input logic v, input logic pp);
    drive_pin = {(!v) || pp, v};
  endfunction

  // ****************************************
  // Pin sampling and clock output
  // ****************************************
  pxb_pin_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (pin_in),
    .q      (pin_s)
  );

  pxb_clock_out_div u_clkdiv (
    .clk     (clk),
    .arst_n  (arst_n),
    .div     (clock_out_divider),
    .clk_out (clock_out)
  );

  // ****************************************
  // Register access
  // ****************************************
  assign latch     = {state.port2_data_latch, state.port1_data_latch, state.port0_data_latch};
  assign push_pull = {state.port2_drive_select, state.port1_drive_select, state.port0_drive_select};
  assign analog    = {8'h00, ~state.port1_analog_digital_select, 8'h00};
  // Analog pins read zero; all others return the pin itself
  assign pin_rd    = pin_s & ~analog;

  assign crossbar_on       = state.crossbar_route_c[RC_XBAR];
  assign pullup_global_off = state.crossbar_route_c[RC_PUOFF];
  assign memif_low_port_en = state.crossbar_route_c[RC_MEMIF];

  always_comb begin
    next_state = state;
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_PORT0_LATCH: next_state.port0_data_latch = sfr_wdata;
        ADDR_PORT1_LATCH: next_state.port1_data_latch = sfr_wdata;
        ADDR_PORT2_LATCH: next_state.port2_data_latch = sfr_wdata;
        ADDR_PORT0_DRIVE: next_state.port0_drive_select = sfr_wdata;
        ADDR_PORT1_DRIVE: next_state.port1_drive_select = sfr_wdata;
        ADDR_PORT2_DRIVE: next_state.port2_drive_select = sfr_wdata;
        ADDR_PORT1_ADSEL: next_state.port1_analog_digital_select = sfr_wdata;
        ADDR_ROUTE_B: next_state.crossbar_route_b = sfr_wdata;
        ADDR_ROUTE_C: next_state.crossbar_route_c = sfr_wdata;
        default: next_state.rdata = state.rdata;
      endcase
    end
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_PORT0_LATCH: next_state.rdata = pin_rd[PORT_W-1:0];
        ADDR_PORT1_LATCH: next_state.rdata = pin_rd[PORT1_LSB +: PORT_W];
        ADDR_PORT2_LATCH: next_state.rdata = pin_rd[PORT2_LSB +: PORT_W];
        ADDR_PORT0_DRIVE: next_state.rdata = state.port0_drive_select;
        ADDR_PORT1_DRIVE: next_state.rdata = state.port1_drive_select;
        ADDR_PORT2_DRIVE: next_state.rdata = state.port2_drive_select;
        ADDR_PORT1_ADSEL: next_state.rdata = state.port1_analog_digital_select;
        ADDR_ROUTE_B: next_state.rdata = state.crossbar_route_b;
        ADDR_ROUTE_C: next_state.rdata = state.crossbar_route_c;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.port0_data_latch <= RST_LATCH;
      state.port1_data_latch <= RST_LATCH;
      state.port2_data_latch <= RST_LATCH;
      state.port0_drive_select <= RST_DRIVE;
      state.port1_drive_select <= RST_DRIVE;
      state.port2_drive_select <= RST_DRIVE;
      state.port1_analog_digital_select <= RST_ADSEL;
      state.crossbar_route_b <= RST_ROUTE;
      state.crossbar_route_c <= RST_ROUTE;
      state.rdata <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign sfr_rdata = state.rdata;

  // ****************************************
  // Memory interface pins and skip mask
  // ****************************************
  always_comb begin
    memif_drv = '0;
    memif_val = '0;
    skip      = reserved_pins | analog;
    if (memif_low_port_en) begin
      skip[PIN_WR_N] = 1'b1;
      skip[PIN_RD_N] = 1'b1;
      skip[PIN_ALE]  = skip[PIN_ALE] || !memif_nonmux;
      memif_drv[PIN_WR_N] = memif_active;
      memif_drv[PIN_RD_N] = memif_active;
      memif_drv[PIN_ALE]  = memif_active && !memif_nonmux;
      memif_val[PIN_WR_N] = memif_wr_n;
      memif_val[PIN_RD_N] = memif_rd_n;
      memif_val[PIN_ALE]  = memif_ale;
      memif_drv[PORT2_LSB +: PORT_W] = {PORT_W{memif_active}};
      if (memif_nonmux) begin
        memif_drv[PORT1_LSB +: PORT_W] = {PORT_W{memif_active}};
        memif_val[PORT1_LSB +: PORT_W] = memif_addr[15:8];
        memif_val[PORT2_LSB +: PORT_W] = memif_addr[7:0];
      end else begin
        memif_val[PORT2_LSB +: PORT_W] = memif_addr[15:8];
      end
    end
  end

  // ****************************************
  // Priority assignment
  // ****************************************
  always_comb begin
    fn_en = '0;
    fn_en[FN_TX1]    = state.crossbar_route_c[RC_UART];
    fn_en[FN_RX1]    = state.crossbar_route_c[RC_UART];
    fn_en[FN_CP1]    = state.crossbar_route_b[RB_CP1];
    fn_en[FN_T0]     = state.crossbar_route_b[RB_T0];
    fn_en[FN_INT0]   = state.crossbar_route_b[RB_INT0];
    fn_en[FN_T1]     = state.crossbar_route_b[RB_T1];
    fn_en[FN_INT1]   = state.crossbar_route_b[RB_INT1];
    fn_en[FN_T2]     = state.crossbar_route_b[RB_T2];
    fn_en[FN_T2EX]   = state.crossbar_route_b[RB_T2EX];
    fn_en[FN_T4]     = state.crossbar_route_c[RC_T4];
    fn_en[FN_T4EX]   = state.crossbar_route_c[RC_T4EX];
    fn_en[FN_CLKOUT] = state.crossbar_route_b[RB_CLKOUT];
    fn_en[FN_CONV_A] = state.crossbar_route_c[RC_CONV_A];
    fn_en[FN_CONV_B] = state.crossbar_route_c[RC_CONV_B];
    fn_is_out = '0;
    fn_is_out[FN_TX1]    = 1'b1;
    fn_is_out[FN_CP1]    = 1'b1;
    fn_is_out[FN_CLKOUT] = 1'b1;
    fn_out = '0;
    fn_out[FN_TX1]    = second_uart_tx;
    fn_out[FN_CP1]    = comparator1_out;
    fn_out[FN_CLKOUT] = clock_out;
  end

  // Fully unrolled search; cheap at this pin count and keeps it one cycle
  always_comb begin
    ptr       = 0;
    found     = 1'b0;
    fn_valid  = '0;
    pin_owned = '0;
    for (int f = 0; f < NFN; f++) begin
      pin_of[f] = '0;
    end
    for (int p = 0; p < NPIN; p++) begin
      pin_fn[p] = '0;
    end
    for (int f = 0; f < NFN; f++) begin
      found = 1'b0;
      if (fn_en[f]) begin
        for (int p = 0; p < NPIN; p++) begin
          if (!found && p >= ptr && !skip[p]) begin
            found       = 1'b1;
            pin_of[f]   = p[4:0];
            pin_fn[p]   = f[3:0];
            pin_owned[p] = 1'b1;
            ptr         = p + 1;
          end
        end
      end
      fn_valid[f] = found;
    end
  end

  // Unrouted inputs idle high so peripherals see no edges
  always_comb begin
    for (int f = 0; f < NFN; f++) begin
      periph_in[f] = (crossbar_on && fn_valid[f] && !fn_is_out[f]) ? pin_s[pin_of[f]] : 1'b1;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic v;
    logic od;
    logic [1:0] drv;
    always_comb begin
      od = 1'b0;
      if (reserved_pins[p]) begin
        v  = reserved_out[p];
        od = reserved_od[p];
      end else if (pin_owned[p] && fn_is_out[pin_fn[p]]) begin
        v = fn_out[pin_fn[p]];
      end else if (memif_drv[p]) begin
        v = memif_val[p];
      end else begin
        v  = latch[p];
        od = pin_owned[p] && (pin_fn[p] == FN_RX1[3:0]) && second_uart_mode0;
      end
      drv        = drive_pin(v, push_pull[p] && !od);
      pin_oe[p]  = crossbar_on && drv[1];
      pin_out[p] = drv[0];
      // A pin driving low never fights its own pullup
      pullup_en[p] = !pullup_global_off && !analog[p] && !(pin_oe[p] && !v);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  xbar_off_input_a: assert property (!crossbar_on |-> pin_oe == '0)
    else $error("pin driven while crossbar off");
  pullup_global_a: assert property (pullup_global_off |-> pullup_en == '0)
    else $error("pullup on while globally disabled");
  analog_pullup_a: assert property ((pullup_en & analog) == '0)
    else $error("pullup on an analog pin");
  analog_read_a: assert property (sfr_rd && sfr_addr == ADDR_PORT1_LATCH
    |=> (sfr_rdata & ~state.port1_analog_digital_select) == 8'h00)
    else $error("analog pin read non-zero");
  port0_read_a: assert property ($stable(pin_in) [*3] ##0 (sfr_rd && sfr_addr == ADDR_PORT0_LATCH)
    |=> sfr_rdata == $past(pin_in[PORT_W-1:0], 1))
    else $error("port read does not follow pin");
  uart_off_a: assert property (!state.crossbar_route_c[RC_UART] |-> fn_valid[FN_RX1:FN_TX1] == 2'h0)
    else $error("uart routed while disabled");
  cp1_off_a: assert property (!state.crossbar_route_b[RB_CP1] |-> !fn_valid[FN_CP1])
    else $error("comparator routed while disabled");
  clkout_off_a: assert property (!state.crossbar_route_b[RB_CLKOUT] |-> !fn_valid[FN_CLKOUT])
    else $error("clock out routed while disabled");
  memif_skip_a: assert property (memif_low_port_en && !memif_nonmux
    |-> pin_owned[PIN_WR_N:PIN_ALE] == 3'h0)
    else $error("memory pins given to crossbar");
  gpio_low_a: assert property (crossbar_on && !reserved_pins[0] && !pin_owned[0] && !memif_drv[0]
    && !latch[0] |-> pin_oe[0] && !pin_out[0])
    else $error("latch zero not driven low");
  latch_write_a: assert property (sfr_wr && sfr_addr == ADDR_PORT2_LATCH
    |=> latch[PORT2_LSB +: PORT_W] == $past(sfr_wdata))
    else $error("port latch write lost");
endmodule
`default_nettype wire

// *** testbench/pxb_pin_model.sv ***
`default_nettype none
module pxb_pin_model (
  input  wire logic        clk,
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pullup_en,
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] ext_val,
  output logic      [23:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] float_q = 24'h000000;
  // A pin nobody drives or pulls flips every cycle, so a stale level cannot pass for a real one
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  // The device wins over the outside world; the pullup only matters on a released pin
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & pullup_en) | (~pin_oe & ~ext_en & ~pullup_en & float_q);
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pxb_pkg::*;
  logic clk, arst_n, sfr_wr, sfr_rd, uart_tx, uart_m0, cmp1, m_act, m_nm, m_wr_n, m_rd_n, m_ale;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [23:0] pin_lvl, pin_out, pin_oe, pullup_en, res_pins, res_out, res_od, ext_en, ext_val;
  logic [15:0] m_addr;
  logic [NFN-1:0] periph_in;
  pxb_clk_div_type div;
  int mismatches = 0;
  int n_compared = 0;

  pxb_port_crossbar u_pxb_port_crossbar (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .reserved_pins(res_pins), .reserved_out(res_out),
    .reserved_od(res_od), .second_uart_tx(uart_tx), .second_uart_mode0(uart_m0), .comparator1_out(cmp1),
    .clock_out_divider(div), .memif_active(m_act), .memif_nonmux(m_nm), .memif_wr_n(m_wr_n),
    .memif_rd_n(m_rd_n), .memif_ale(m_ale), .memif_addr(m_addr), .periph_in(periph_in));
  pxb_pin_model u_pxb_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask
  // Pin levels pass two synchroniser flops before reads or routed inputs see them
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic gpio_base();
    wr(ADDR_ROUTE_B, 8'h00);
    wr(ADDR_ROUTE_C, 8'h40);
    wr(ADDR_PORT0_DRIVE, 8'h00);
    wr(ADDR_PORT0_LATCH, 8'hFF);
    wr(ADDR_PORT1_LATCH, 8'hFF);
    wr(ADDR_PORT2_LATCH, 8'hFF);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] a[6] = '{8'hA4, 8'hA5, 8'hAD, 8'hE2, 8'hE3, 8'h55};
    logic [7:0] e[6] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    foreach (a[i]) begin
      rd(a[i], d);
      chk(d, e[i]);
    end
    chk(pin_oe, 24'h0);
    chk(pullup_en, 24'hFFFFFF);
    rd(ADDR_PORT0_LATCH, d);
    chk(d, 8'hFF);
    $display("test reset done");
  endtask
  task automatic t_drive();
    wr(ADDR_PORT0_LATCH, 8'h00);
    chk(pin_oe, 24'h0);
    chk(periph_in, 14'h3FFF);
    wr(ADDR_ROUTE_C, 8'h40);
    chk({pin_oe[7:0], pin_out[7:0]}, 24'hFF00);
    wr(ADDR_PORT0_LATCH, 8'hFF);
    wr(ADDR_PORT0_DRIVE, 8'hF0);
    chk({pin_oe[7:0], pin_out[7:4]}, 24'hF0F);
    $display("test drive done");
  endtask
  task automatic t_pullup();
    logic [7:0] d;
    gpio_base();
    chk(pullup_en, 24'hFFFFFF);
    wr(ADDR_ROUTE_C, 8'hC0);
    chk(pullup_en, 24'h0);
    wr(ADDR_ROUTE_C, 8'h40);
    wr(ADDR_PORT1_ADSEL, 8'h0F);
    chk(pullup_en[15:8], 8'h0F);
    settle();
    rd(ADDR_PORT1_LATCH, d);
    chk(d, 8'h0F);
    wr(ADDR_PORT1_LATCH, 8'h00);
    chk(pin_oe[15:8], 8'hFF);
    wr(ADDR_PORT1_LATCH, 8'hFF);
    wr(ADDR_PORT1_ADSEL, 8'hFF);
    ext_en <= 24'hFFFFFF;
    ext_val <= 24'hA5FFFF;
    settle();
    rd(ADDR_PORT2_LATCH, d);
    chk(d, 8'hA5);
    $display("test pullup done");
  endtask
  task automatic t_inputs();
    logic [7:0] fa[10] = '{8'hE2, 8'hE2, 8'hE2, 8'hE2, 8'hE2, 8'hE2, 8'hE3, 8'hE3, 8'hE3, 8'hE3};
    int fb[10] = '{6, 5, 4, 3, 2, 1, 5, 4, 3, 0};
    int fn[10] = '{FN_T2EX, FN_T2, FN_INT1, FN_T1, FN_INT0, FN_T0, FN_CONV_B, FN_T4EX, FN_T4, FN_CONV_A};
    logic [7:0] on;
    gpio_base();
    foreach (fa[i]) begin
      on = (fa[i] == ADDR_ROUTE_C) ? 8'h40 : 8'h00;
      ext_val[0] <= 1'b0;
      wr(fa[i], on | (8'h01 << fb[i]));
      settle();
      chk(periph_in[fn[i]], 1'b0);
      wr(fa[i], on);
      settle();
      chk(periph_in[fn[i]], 1'b1);
    end
    ext_val[0] <= 1'b1;
    $display("test inputs done");
  endtask
  task automatic t_outputs();
    int n;
    logic p;
    gpio_base();
    wr(ADDR_PORT0_DRIVE, 8'hFF);
    cmp1 <= 1'b0;
    wr(ADDR_ROUTE_B, 8'h01);
    chk({pin_oe[0], pin_out[0]}, 24'h2);
    cmp1 <= 1'b1;
    settle();
    chk(pin_out[0], 1'b1);
    cmp1 <= 1'b0;
    wr(ADDR_ROUTE_B, 8'h00);
    chk(pin_out[0], 1'b1);
    for (int d = 0; d < 4; d++) begin
      div <= pxb_clk_div_type'(d);
      wr(ADDR_ROUTE_B, 8'h80);
      settle();
      n = 0;
      p = pin_out[0];
      repeat (16) begin
        @(posedge clk);
        #1;
        if (pin_out[0] !== p) n++;
        p = pin_out[0];
      end
      chk(n, (d == 0) ? 0 : (32 >> d));
      if (d == 0) chk(p, 1'b0);
    end
    wr(ADDR_ROUTE_B, 8'h00);
    $display("test outputs done");
  endtask
  task automatic t_skip(input logic nm, input logic [7:0] ad, input int pin);
    gpio_base();
    @(posedge clk);
    m_nm <= nm;
    uart_tx <= 1'b1;
    ext_val <= ~(24'h1 << pin);
    wr(ADDR_PORT1_ADSEL, ad);
    wr(ADDR_ROUTE_B, 8'h3E);
    wr(ADDR_ROUTE_C, 8'h46);
    settle();
    chk(periph_in[FN_INT1], 1'b0);
    chk({pin_oe[0], pin_out[0]}, 2'b01);
    uart_m0 <= 1'b1;
    wr(ADDR_PORT0_DRIVE, 8'hFF);
    chk(pin_oe[1:0], 2'b01);
    wr(ADDR_ROUTE_B, 8'h00);
    wr(ADDR_ROUTE_C, 8'h42);
    m_act <= 1'b1;
    m_wr_n <= 1'b0;
    m_rd_n <= 1'b1;
    m_ale <= 1'b0;
    m_addr <= 16'h3CA5;
    settle();
    chk(pin_out[7:6], 2'b01);
    if (nm) chk({pin_out[15:8], pin_out[23:16]}, 16'h3CA5);
    else chk({pin_out[5], pin_out[23:16]}, 9'h03C);
    m_act <= 1'b0;
    {uart_tx, uart_m0} <= 2'b00;
    ext_val <= 24'hFFFFFF;
    wr(ADDR_PORT1_ADSEL, 8'hFF);
    $display("test memory skip done");
  endtask
  task automatic t_reserved();
    gpio_base();
    wr(ADDR_PORT0_DRIVE, 8'hFF);
    res_pins <= 24'h8;
    res_out <= 24'h8;
    res_od <= 24'h8;
    settle();
    chk(pin_oe[3], 1'b0);
    res_od <= 24'h0;
    settle();
    chk({pin_oe[3], pin_out[3]}, 24'h3);
    res_pins <= 24'h0;
    $display("test open drain done");
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    {arst_n, sfr_wr, sfr_rd, uart_tx, uart_m0, cmp1, m_act, m_nm} = '0;
    {m_wr_n, m_rd_n, m_ale} = 3'b111;
    {sfr_addr, sfr_wdata, m_addr, div} = '0;
    {res_pins, res_out, res_od, ext_en} = '0;
    ext_val = 24'hFFFFFF;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_drive();
    t_pullup();
    t_inputs();
    t_outputs();
    t_skip(1'b0, 8'hFF, 8);
    t_skip(1'b0, 8'hFE, 9);
    t_skip(1'b1, 8'hFF, 5);
    t_reserved();
    summarize();
  end
endmodule
`default_nettype wire
